// ===== spb_pkg.sv
package spb_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h04;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h08;
  localparam logic [7:0] OFS_RELOAD = 8'h0c;
  localparam logic [7:0] OFS_BUFFER = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [4:0] RST_REQUESTS = 5'h00;
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [1:0] RST_FLAGS = 2'h0;

  // ==========================================================
  // Field positions
  localparam int REQ_START = 0;
  localparam int REQ_RESTART = 1;
  localparam int REQ_STOP = 2;
  localparam int REQ_RECEIVE = 3;
  localparam int REQ_ACK = 4;
  localparam int FLAG_EVENT = 0;
  localparam int FLAG_COLLISION = 1;

  // ==========================================================
  // Modes
  localparam logic [3:0] MODE_I2C_MASTER = 4'h8;
  localparam logic [3:0] MODE_SPI_BRG = 4'ha;
  localparam logic [3:0] MODE_I2C_FW = 4'hb;
  localparam logic [3:0] MODE_I2C_S7 = 4'h6;
  localparam logic [3:0] MODE_I2C_S10 = 4'h7;
  localparam logic [3:0] MODE_I2C_S7I = 4'he;
  localparam logic [3:0] MODE_I2C_S10I = 4'hf;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int BRG_PRESCALE = 2;
  localparam logic [3:0] LAST_BIT_I2C = 4'h8;
  localparam logic [3:0] LAST_BIT_SPI = 4'h7;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================
  // Types
  typedef struct packed {
    logic input_sample_phase;
    logic edge_select;
    logic data_not_address;
    logic stop_seen;
    logic start_seen;
    logic read_write;
    logic address_update_needed;
    logic buffer_full;
  } spb_status_s;

  typedef struct packed {
    logic write_collision;
    logic receive_overflow;
    logic port_enable;
    logic clock_polarity;
    logic [3:0] port_mode_select;
  } spb_ctrl_one_s;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_STOP_LOW = 7'b0000010,
    ST_STOP_SCL = 7'b0000100,
    ST_STOP_HIGH = 7'b0001000,
    ST_STOP_REL = 7'b0010000,
    ST_STOP_END = 7'b0100000,
    ST_SHIFT = 7'b1000000
  } spb_state_e;

endpackage

// ===== spb_serial_port.sv
`timescale 1ns/1ps
// Contract
// RL1: Stop: after release and counter expiry, data still low flags a collision.
// RL2: Stop: clock seen low after release, before data high, flags a collision.
// RL3: Stop drives data low, releases clock, counts one reload period, then samples data.
// RL4: Shift buffer write in master modes starts the bit-rate counter from reload.
// RL5: After an operation the counter stops and the clock pin keeps its level.
// RL6: Counter reloads twice per generated serial clock period.
// RL7: Serial clock equals clock divided by four times reload plus one.
// RL8: Software avoids reload values zero, one and two for I2C.
// RL9: Status bit 7 picks SPI sample point; I2C slew choice.
// RL10: Status bit 6 picks SPI data edge; I2C SMBus thresholds.
// RL11: Status bit 5 shows whether the last I2C byte was data.
// RL12: Status bit 4 marks Stop detected last; cleared on reset and disable.
// RL13: Status bit 3 marks Start detected last; cleared on reset and disable.
// RL14: Status bit 2 reads one while master transmission is in progress.
// RL15: Master idle only when transmit bit and all request bits are zero.
// RL16: Status bit 1 flags a needed address update in 10-bit slave addressing; the code always holds it at zero.
// RL17: Status bit 0 shows buffer full or I2C data shifting out.
// RL18: Buffer write during transmission sets the write collision bit.
// RL19: New byte while buffer full sets overflow, slave only; software clears.
// RL20: Control bit 5 enables the port and hands pins to it.
// RL21: Control bit 4 selects SPI clock idle level.
// RL22: Any collision sets the collision flag and returns the port to idle.
// RL23: Collision aborts the sequence, releases both lines, clears request bits.
// RL24: One counter period after a good Stop, clear stop request, set event flag.
// RL25: Bit-rate counter is an 8-bit down counter reloading and expiring at zero.
// RL26: Reset clears status, hardware-set control bits and stops counting.
module spb_serial_port
  import spb_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic sck_out,
  output logic sdo_out,
  input wire logic sdi_in,
  output logic i2c_pins_active,
  output logic spi_pins_active,
  output logic master_busy
);

  // ==========================================================
  // Declarations
  spb_state_e state, next_state;
  spb_status_s status, next_status;
  spb_ctrl_one_s ctrl_one, next_ctrl_one;
  logic [4:0] requests, next_requests;
  logic [1:0] flags, next_flags;
  logic [7:0] reload, next_reload;
  logic [7:0] bit_rate_counter, next_bit_rate_counter;
  logic div_cnt, next_div_cnt;
  logic [7:0] shift_register, next_shift_register;
  logic [7:0] rx_shift, next_rx_shift;
  logic [7:0] shift_buffer, next_shift_buffer;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic half, next_half;
  logic sda_drive, next_sda_drive;
  logic scl_drive, next_scl_drive;
  logic sck_q, next_sck_q;
  logic address_next, next_address_next;
  logic [2:0] sync1, sync2, sync3, filt, next_filt;
  logic sda_prev, scl_prev;
  logic sda_f, scl_f, sdi_f;
  logic div_en, brg_expire, brg_load, collision;
  logic i2c_mode, master_brg;
  logic [3:0] last_bit;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [7:0] w_data, next_w_data;
  logic w_lane0, next_w_lane0;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [7:0] rdata, next_rdata, rd_mux;
  logic wr_go, wr_hit, rd_hit, ar_take, rd_buffer;

  // ==========================================================
  // Pin synchronisers
  assign sda_f = filt[0];
  assign scl_f = filt[1];
  assign sdi_f = filt[2];

  always_comb begin
    next_filt = ((sync2 ~^ sync3) & sync2) | ((sync2 ^ sync3) & filt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 3'h3;
      sync2 <= 3'h3;
      sync3 <= 3'h3;
      filt <= 3'h3;
      sda_prev <= 1'b1;
      scl_prev <= 1'b1;
    end else begin
      sync1 <= {sdi_in, scl_in, sda_in};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      sda_prev <= sda_f;
      scl_prev <= scl_f;
    end
  end

  // ==========================================================
  // Mode decode and pins
  assign i2c_mode = (ctrl_one.port_mode_select == MODE_I2C_MASTER) || (ctrl_one.port_mode_select == MODE_I2C_FW) ||
                    (ctrl_one.port_mode_select == MODE_I2C_S7) || (ctrl_one.port_mode_select == MODE_I2C_S10) ||
                    (ctrl_one.port_mode_select == MODE_I2C_S7I) || (ctrl_one.port_mode_select == MODE_I2C_S10I);
  assign master_brg = (ctrl_one.port_mode_select == MODE_I2C_MASTER) || (ctrl_one.port_mode_select == MODE_SPI_BRG);
  assign last_bit = i2c_mode ? LAST_BIT_I2C : LAST_BIT_SPI;
  assign i2c_pins_active = ctrl_one.port_enable & i2c_mode; // RL20
  assign spi_pins_active = ctrl_one.port_enable & ~i2c_mode; // RL20
  assign master_busy = status.read_write | (|requests); // RL15
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = ~scl_drive;
  assign sda_oe_n = ~sda_drive;
  assign sck_out = sck_q;
  assign sdo_out = shift_register[7];

  // ==========================================================
  // Bit-rate counter timing
  assign div_en = (div_cnt == 1'(BRG_PRESCALE - 1));
  assign brg_expire = div_en && (bit_rate_counter == 8'h00) && (state != ST_IDLE); // RL25 RL5

  // ==========================================================
  // Core next state
  always_comb begin
    next_state = state;
    next_status = status;
    next_ctrl_one = ctrl_one;
    next_requests = requests;
    next_flags = flags;
    next_reload = reload;
    next_bit_rate_counter = bit_rate_counter;
    next_div_cnt = div_cnt + 1'b1;
    next_shift_register = shift_register;
    next_rx_shift = rx_shift;
    next_shift_buffer = shift_buffer;
    next_bit_cnt = bit_cnt;
    next_half = half;
    next_sda_drive = sda_drive;
    next_scl_drive = scl_drive;
    next_sck_q = sck_q;
    next_address_next = address_next;
    brg_load = 1'b0;
    collision = 1'b0;
    if (rd_buffer) begin
      next_status.buffer_full = 1'b0;
    end
    if (wr_go && w_lane0) begin
      case (aw_addr[7:0])
        OFS_STATUS: begin
          next_status.input_sample_phase = w_data[7]; // RL9
          next_status.edge_select = w_data[6]; // RL10
        end
        OFS_CTRL_ONE: begin
          next_ctrl_one.write_collision = ctrl_one.write_collision & w_data[7];
          next_ctrl_one.receive_overflow = ctrl_one.receive_overflow & w_data[6];
          next_ctrl_one.port_enable = w_data[5];
          next_ctrl_one.clock_polarity = w_data[4];
          next_ctrl_one.port_mode_select = w_data[3:0];
        end
        OFS_CTRL_TWO: begin
          if (master_busy) begin
            next_requests = requests & w_data[4:0];
          end else begin
            next_requests = w_data[4:0];
            if (w_data[REQ_STOP] && ctrl_one.port_enable && i2c_mode) begin
              next_scl_drive = 1'b1;
              next_state = ST_STOP_LOW;
            end
          end
        end
        OFS_RELOAD: begin
          next_reload = w_data; // RL8
        end
        OFS_BUFFER: begin
          if (state != ST_IDLE) begin
            next_ctrl_one.write_collision = 1'b1; // RL18
          end else begin
            next_shift_register = w_data;
            if (master_brg && ctrl_one.port_enable) begin
              brg_load = 1'b1; // RL4
              next_state = ST_SHIFT;
              next_bit_cnt = 4'h0;
              next_half = 1'b0;
              if (i2c_mode) begin
                next_status.buffer_full = 1'b1; // RL17
                next_status.read_write = 1'b1; // RL14
                next_scl_drive = 1'b1;
                next_sda_drive = ~w_data[7];
              end else begin
                next_sck_q = ctrl_one.clock_polarity ^ ~status.edge_select; // RL10
              end
            end
          end
        end
        OFS_FLAGS: begin
          next_flags = flags & ~w_data[1:0];
        end
        default: begin
        end
      endcase
    end
    case (state)
      ST_IDLE: begin
        if (!i2c_mode && (next_state == ST_IDLE)) begin
          next_sck_q = next_ctrl_one.clock_polarity; // RL21
        end
      end
      ST_STOP_LOW: begin
        next_sda_drive = 1'b1;
        if (sda_f) begin
          brg_load = 1'b1; // RL3
        end else if (brg_expire) begin
          next_scl_drive = 1'b0; // RL3
          next_state = ST_STOP_SCL;
        end
      end
      ST_STOP_SCL: begin
        if (scl_f) begin
          brg_load = 1'b1; // RL3
          next_state = ST_STOP_HIGH;
        end
      end
      ST_STOP_HIGH: begin
        if (!scl_f) begin
          collision = 1'b1; // RL2
        end else if (brg_expire) begin
          next_sda_drive = 1'b0;
          brg_load = 1'b1;
          next_state = ST_STOP_REL;
        end
      end
      ST_STOP_REL: begin
        if (!scl_f && !sda_f) begin
          collision = 1'b1; // RL2
        end else if (brg_expire) begin
          if (!sda_f) begin
            collision = 1'b1; // RL1
          end else begin
            brg_load = 1'b1;
            next_state = ST_STOP_END;
          end
        end
      end
      ST_STOP_END: begin
        if (brg_expire) begin
          next_requests[REQ_STOP] = 1'b0; // RL24
          next_flags[FLAG_EVENT] = 1'b1; // RL24
          next_state = ST_IDLE;
        end
      end
      ST_SHIFT: begin
        if (!half) begin
          if (brg_expire) begin
            next_half = 1'b1; // RL6
            if (i2c_mode) begin
              next_scl_drive = 1'b0;
            end else begin
              next_sck_q = ctrl_one.clock_polarity ^ status.edge_select; // RL10
              if (!status.input_sample_phase) begin
                next_rx_shift = {rx_shift[6:0], sdi_f}; // RL9
              end
            end
          end
        end else if (i2c_mode && !scl_f) begin
          brg_load = 1'b1;
        end else if (brg_expire) begin
          next_half = 1'b0; // RL6
          if (!i2c_mode && status.input_sample_phase) begin
            next_rx_shift = {rx_shift[6:0], sdi_f}; // RL9
          end
          if (i2c_mode && (bit_cnt <= LAST_DATA_BIT) && !sda_drive && !sda_f) begin
            collision = 1'b1;
          end
          if (i2c_mode && (bit_cnt == LAST_DATA_BIT)) begin
            next_status.buffer_full = 1'b0; // RL17
            next_status.data_not_address = ~address_next; // RL11
            next_address_next = 1'b0;
          end
          if (bit_cnt == last_bit) begin
            next_state = ST_IDLE; // RL5
            if (i2c_mode) begin
              next_scl_drive = 1'b1;
              next_status.read_write = 1'b0; // RL14
            end else begin
              next_sck_q = ctrl_one.clock_polarity;
              next_shift_buffer = status.input_sample_phase ? {rx_shift[6:0], sdi_f} : rx_shift; // RL9
              if (status.buffer_full && !master_brg) begin
                next_ctrl_one.receive_overflow = 1'b1; // RL19
              end else begin
                next_status.buffer_full = 1'b1; // RL17
              end
            end
          end else begin
            next_bit_cnt = bit_cnt + 4'h1;
            next_shift_register = {shift_register[6:0], 1'b0};
            if (i2c_mode) begin
              next_scl_drive = 1'b1;
              next_sda_drive = (bit_cnt == LAST_DATA_BIT) ? 1'b0 : ~shift_register[6];
            end else begin
              next_sck_q = ctrl_one.clock_polarity ^ ~status.edge_select; // RL10
            end
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (brg_load) begin
      next_bit_rate_counter = reload; // RL25
    end else if (div_en && (state != ST_IDLE)) begin
      next_bit_rate_counter = brg_expire ? reload : bit_rate_counter - 8'h01; // RL25 RL6 RL7
    end
    if (i2c_mode && ctrl_one.port_enable && scl_f && scl_prev) begin
      if (sda_prev && !sda_f) begin
        next_status.start_seen = 1'b1; // RL13
        next_status.stop_seen = 1'b0;
        next_address_next = 1'b1;
      end else if (!sda_prev && sda_f) begin
        next_status.stop_seen = 1'b1; // RL12
        next_status.start_seen = 1'b0;
      end
    end
    next_status.address_update_needed = 1'b0; // RL16
    if (collision) begin
      next_flags[FLAG_COLLISION] = 1'b1; // RL22
      next_state = ST_IDLE; // RL22
      next_sda_drive = 1'b0; // RL23
      next_scl_drive = 1'b0; // RL23
      next_requests = RST_REQUESTS; // RL23
      next_status.buffer_full = 1'b0;
      next_status.read_write = 1'b0;
    end
    if (!next_ctrl_one.port_enable) begin
      next_state = ST_IDLE; // RL20
      next_sda_drive = 1'b0;
      next_scl_drive = 1'b0;
      next_requests = RST_REQUESTS;
      next_status.start_seen = 1'b0; // RL13
      next_status.stop_seen = 1'b0; // RL12
      next_status.buffer_full = 1'b0; // RL17
      next_status.read_write = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE; // RL26
      status <= spb_status_s'(RST_STATUS); // RL26
      ctrl_one <= spb_ctrl_one_s'(RST_CTRL_ONE); // RL26
      requests <= RST_REQUESTS;
      flags <= RST_FLAGS;
      reload <= RST_RELOAD;
      bit_rate_counter <= 8'h00;
      div_cnt <= 1'b0;
      shift_register <= 8'h00;
      rx_shift <= 8'h00;
      shift_buffer <= 8'h00;
      bit_cnt <= 4'h0;
      half <= 1'b0;
      sda_drive <= 1'b0;
      scl_drive <= 1'b0;
      sck_q <= 1'b0;
      address_next <= 1'b0;
    end else begin
      state <= next_state;
      status <= next_status;
      ctrl_one <= next_ctrl_one;
      requests <= next_requests;
      flags <= next_flags;
      reload <= next_reload;
      bit_rate_counter <= next_bit_rate_counter;
      div_cnt <= next_div_cnt;
      shift_register <= next_shift_register;
      rx_shift <= next_rx_shift;
      shift_buffer <= next_shift_buffer;
      bit_cnt <= next_bit_cnt;
      half <= next_half;
      sda_drive <= next_sda_drive;
      scl_drive <= next_scl_drive;
      sck_q <= next_sck_q;
      address_next <= next_address_next;
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  assign s_axi_awready = ~aw_held & ~bvalid;
  assign s_axi_wready = ~w_held & ~bvalid;
  assign s_axi_arready = ~rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = {24'h000000, rdata};
  assign wr_go = aw_held & w_held & ~bvalid;
  assign ar_take = s_axi_arvalid & ~rvalid;
  assign wr_hit = (aw_addr[7:0] == OFS_STATUS) || (aw_addr[7:0] == OFS_CTRL_ONE) ||
                  (aw_addr[7:0] == OFS_CTRL_TWO) || (aw_addr[7:0] == OFS_RELOAD) ||
                  (aw_addr[7:0] == OFS_BUFFER) || (aw_addr[7:0] == OFS_FLAGS);
  assign rd_hit = (s_axi_araddr[7:0] == OFS_STATUS) || (s_axi_araddr[7:0] == OFS_CTRL_ONE) ||
                  (s_axi_araddr[7:0] == OFS_CTRL_TWO) || (s_axi_araddr[7:0] == OFS_RELOAD) ||
                  (s_axi_araddr[7:0] == OFS_BUFFER) || (s_axi_araddr[7:0] == OFS_FLAGS);
  assign rd_buffer = ar_take && (s_axi_araddr[7:0] == OFS_BUFFER);

  always_comb begin
    case (s_axi_araddr[7:0])
      OFS_STATUS: rd_mux = status;
      OFS_CTRL_ONE: rd_mux = ctrl_one;
      OFS_CTRL_TWO: rd_mux = {master_busy, 2'b00, requests}; // RL15
      OFS_RELOAD: rd_mux = reload;
      OFS_BUFFER: rd_mux = shift_buffer;
      OFS_FLAGS: rd_mux = {6'h00, flags};
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (ar_take) begin
      next_rvalid = 1'b1;
      next_rdata = rd_mux;
      next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 8'h00;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

endmodule

// ===== spb_peer_model.sv
`timescale 1ns/1ps
// =====
// Bus peer with pull-ups and SPI loopback
module spb_peer_model (
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic sdo_out,
  input wire logic hold_scl_low,
  input wire logic hold_sda_low,
  output logic scl,
  output logic sda,
  output logic sdi
);
  assign scl = scl_oe_n && !hold_scl_low;
  assign sda = sda_oe_n && !hold_sda_low;
  assign sdi = sdo_out;
endmodule

// ===== spb_serial_port_monitor.sv
`timescale 1ns/1ps
// =====
// Port checks
module spb_serial_port_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic i2c_pins_active,
  input wire logic spi_pins_active,
  input wire logic master_busy
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_idle: assert property (disable iff (1'h0) !aresetn |=> scl_oe_n && sda_oe_n && !master_busy)
    else $error("not idle after reset");
  a_pins_one_mode: assert property (!(i2c_pins_active && spi_pins_active))
    else $error("both pin sets active");
  a_off_released: assert property ((!i2c_pins_active && !spi_pins_active) [*2] |-> scl_oe_n && sda_oe_n)
    else $error("lines pulled while disabled");
  a_scl_holds: assert property ($fell(master_busy) && i2c_pins_active |=> $stable(scl_oe_n) [*3])
    else $error("clock pin moved after operation");
  a_pull_busy: assert property (!sda_oe_n |-> master_busy)
    else $error("data pulled while idle");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped early");
endmodule

bind spb_serial_port spb_serial_port_monitor mon_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .scl_oe_n, .sda_oe_n, .i2c_pins_active, .spi_pins_active, .master_busy);

// ===== spb_serial_port_test.sv
`timescale 1ns/1ps
// =====
// Bench
module spb_serial_port_test;
  import spb_pkg::*;
  localparam logic [7:0] RLD = 8'h03;
  logic aclk = 1'h0, aresetn = 1'h0, hold_scl_low = 1'h0, hold_sda_low = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, d;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, scl_in, sda_in, sdi_in;
  logic scl_oe_n, sda_oe_n, sck_out, sdo_out, i2c_pins_active, spi_pins_active, master_busy;
  int n_mismatch = 0, checks = 0, cyc = 0;
  time t0;
  always #50 aclk = ~aclk;
  spb_serial_port dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_in,
    .scl_out(), .scl_oe_n, .sda_in, .sda_out(), .sda_oe_n, .sck_out, .sdo_out, .sdi_in, .i2c_pins_active,
    .spi_pins_active, .master_busy);
  spb_peer_model peer_u (.scl_oe_n, .sda_oe_n, .sdo_out, .hold_scl_low, .hold_sda_low, .scl(scl_in),
    .sda(sda_in), .sdi(sdi_in));
  // =====
  // Tasks
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task wait_idle;
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (master_busy !== 1'h0 && n < 3000);
    if (n >= 3000) n_mismatch++;
  endtask
  task close_out;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      close_out;
    end
  end
  // =====
  // Tests
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(OFS_STATUS); chk(d, RST_STATUS);
    rd(OFS_CTRL_ONE); chk(d, RST_CTRL_ONE);
    rd(8'h18); chk({6'h0, resp}, {6'h0, RESP_SLVERR});
    $display("test reset done");
    wr(OFS_CTRL_ONE, {4'h2, MODE_I2C_MASTER}); chk({7'h0, i2c_pins_active}, 8'h01);
    wr(OFS_RELOAD, RLD);
    wr(OFS_CTRL_TWO, 8'h04);
    wait_idle;
    rd(OFS_STATUS); chk(d & 8'h18, 8'h10);
    rd(OFS_FLAGS); chk(d, 8'h01);
    wr(OFS_FLAGS, 8'h03);
    hold_sda_low <= 1'h1;
    wr(OFS_CTRL_TWO, 8'h04);
    wait_idle;
    chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
    rd(OFS_FLAGS); chk(d, 8'h02);
    rd(OFS_CTRL_TWO); chk(d, 8'h00);
    hold_sda_low <= 1'h0;
    wr(OFS_FLAGS, 8'h03);
    $display("test stop done");
    wr(OFS_BUFFER, 8'ha5);
    rd(OFS_STATUS); chk(d & 8'h05, 8'h05);
    wr(OFS_BUFFER, 8'h3c);
    rd(OFS_CTRL_ONE); chk(d, 8'ha8);
    hold_scl_low <= 1'h1;
    repeat (40) @(posedge aclk);
    chk({7'h0, master_busy}, 8'h01);
    hold_scl_low <= 1'h0;
    wait_idle;
    rd(OFS_STATUS); chk(d & 8'h05, 8'h00);
    wr(OFS_CTRL_ONE, 8'h28);
    rd(OFS_CTRL_ONE); chk(d, 8'h28);
    wr(OFS_CTRL_ONE, 8'h00);
    rd(OFS_STATUS); chk(d & 8'h1d, 8'h00);
    $display("test i2c done");
    wr(OFS_CTRL_ONE, {4'h2, MODE_SPI_BRG}); chk({7'h0, spi_pins_active}, 8'h01);
    wr(OFS_BUFFER, 8'h96);
    @(posedge sck_out);
    t0 = $time;
    @(posedge sck_out);
    chk(8'(($time - t0) / CLK_PERIOD_NS), 8'(4 * (RLD + 1)));
    repeat (8 * 4 * (RLD + 1)) @(posedge aclk);
    rd(OFS_STATUS); chk(d & 8'h01, 8'h01);
    rd(OFS_BUFFER); chk(d, 8'h96);
    rd(OFS_STATUS); chk(d & 8'h01, 8'h00);
    wr(OFS_CTRL_ONE, {4'h3, MODE_SPI_BRG}); chk({7'h0, sck_out}, 8'h01);
    wr(OFS_STATUS, 8'hc0);
    wr(OFS_BUFFER, 8'h69);
    repeat (9 * 4 * (RLD + 1)) @(posedge aclk);
    rd(OFS_BUFFER); chk(d, 8'h69);
    chk({7'h0, sck_out}, 8'h01);
    wr(OFS_CTRL_ONE, 8'h00);
    $display("test spi done");
    close_out;
  end
endmodule
